// ### bkpt_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "spr_map_cfg.svh"

// Registered address compare against one breakpoint register.
module bkpt_match (
	input  wire logic        mclk,   // Core clock.
	input  wire logic        srst,   // Synchronous reset.
	input  wire logic [31:0] bkpt,   // Breakpoint word, bit 0 enables.
	input  wire logic        valid,  // Access address is valid.
	input  wire logic [31:0] addr,   // Access address.
	output var  logic        hit     // Registered match flag, high the cycle after each matching access.
);

	logic hit_d;

	// Word address compare; the low bits carry the enable.
	always_comb begin
		hit_d = valid && bkpt[`BKPT_ENABLE_BIT] &&
			(addr[31:2] == bkpt[31:2]);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			hit <= 1'b0;
		end else begin
			hit <= hit_d;
		end
	end

endmodule // bkpt_match

`default_nettype wire

// ### core_special_register_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "spr_map_cfg.svh"

module core_special_register_map (
	input  wire logic                      mclk,        // Core clock.
	input  wire logic                      srst,        // Sync reset.
	input  wire spr_map_pkg::spr_req_t     req,         // Move request.
	output var  spr_map_pkg::spr_rsp_t     rsp,         // Move answer.
	input  wire spr_map_pkg::branch_upd_t  br,          // Branch updates.
	input  wire spr_map_pkg::fault_info_t  flt,         // Fault capture.
	input  wire logic                      bus_tick,    // Bus clock pulse.
	input  wire logic [5:0]                clk_cfg,     // Clock config pins.
	input  wire logic [31:0]               mon_ctl_a,   // Supervisor ctl a.
	input  wire logic [31:0]               mon_ctl_b,   // Supervisor ctl b.
	input  wire logic [31:0]               mon_ctl_c,   // Supervisor ctl c.
	input  wire logic [191:0]              mon_counts,  // Six event counts.
	input  wire logic [31:0]               sampled_pc,  // Sampled address.
	input  wire logic                      fetch_vld,   // Fetch address valid.
	input  wire logic [31:0]               fetch_addr,  // Fetch address.
	input  wire logic                      data_vld,    // Data access valid.
	input  wire logic [31:0]               data_addr,   // Data effective addr.
	input  wire logic [4:0]                fpr_raddr,   // Float read index.
	input  wire logic                      fpr_we,      // Float write enable.
	input  wire logic [4:0]                fpr_waddr,   // Float write index.
	input  wire logic [63:0]               fpr_wdata,   // Float write data.
	output var  logic [63:0]               fpr_rdata,   // Float read data.
	output var  logic [31:0]               cond_flags,  // Condition flags.
	output var  logic [31:0]               loop_target, // Count target.
	output var  logic [31:0]               ret_target,  // Return target.
	output var  logic                      dec_irq,     // Decrementer event.
	output var  logic                      ibkpt_hit,   // Fetch breakpoint.
	output var  logic                      dbkpt_hit,   // Data breakpoint.
	output var  logic [31:0]               impl_a_out   // Impl control a.
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [31:0] xer_q, xer_d;
	logic [31:0] ret_q, ret_d;
	logic [31:0] cnt_q, cnt_d;
	logic [31:0] cause_q, cause_d;
	logic [31:0] faddr_q, faddr_d;
	logic [31:0] dec_q, dec_d;
	logic [31:0] vsave_q, vsave_d;
	logic [31:0] ear_q, ear_d;
	logic [31:0] tbl_q, tbl_d;
	logic [31:0] tbu_q, tbu_d;
	logic [31:0] impla_q, impla_d;
	logic [31:0] implb_q, implb_d;
	logic [31:0] instr_breakpoint_addr_q, instr_breakpoint_addr_d;
	logic [31:0] data_breakpoint_addr_q, data_breakpoint_addr_d;
	logic [31:0] cr_q, cr_d;
	logic        dec_irq_d;
	logic [63:0] fpr_mem [32];
	spr_map_pkg::spr_rsp_t rsp_d;
	logic        tb_tick;
	logic        wr;
	logic        rd;

	// ----------------------------------------------------------------
	// Pacing
	// ----------------------------------------------------------------
	// quarter bus rate
	tick_divider #(
		.DIV(`TB_BUS_DIV)
	) u_tb_div (
		.mclk    (mclk),
		.srst    (srst),
		.bus_tick(bus_tick),
		.tick    (tb_tick)
	);

	// ----------------------------------------------------------------
	// Breakpoints
	// ----------------------------------------------------------------
	// instruction address compare
	bkpt_match u_ibkpt (
		.mclk (mclk),
		.srst (srst),
		.bkpt (instr_breakpoint_addr_q),
		.valid(fetch_vld),
		.addr (fetch_addr),
		.hit  (ibkpt_hit)
	);

	bkpt_match u_dbkpt (
		.mclk (mclk),
		.srst (srst),
		.bkpt (data_breakpoint_addr_q),
		.valid(data_vld),
		.addr (data_addr),
		.hit  (dbkpt_hit)
	);

	assign wr = (req.op == spr_map_pkg::op_move_to);
	assign rd = (req.op == spr_map_pkg::op_move_from);

	// ----------------------------------------------------------------
	// Register writes and hardware updates
	// ----------------------------------------------------------------
	// Hardware updates are applied after software writes so that a
	// same-cycle event is never lost.
	always_comb begin
		xer_d   = xer_q;
		ret_d   = ret_q;
		cnt_d   = cnt_q;
		cause_d = cause_q;
		faddr_d = faddr_q;
		dec_d   = dec_q;
		vsave_d = vsave_q;
		ear_d   = ear_q;
		tbl_d   = tbl_q;
		tbu_d   = tbu_q;
		impla_d = impla_q;
		implb_d = implb_q;
		instr_breakpoint_addr_d  = instr_breakpoint_addr_q;
		data_breakpoint_addr_d  = data_breakpoint_addr_q;
		cr_d    = cr_q;
		dec_irq_d = 1'b0;
		if (wr) begin
			case (req.num)
				`SPRN_XER_FLAGS:   xer_d[`XER_STR_MSB:`XER_STR_LSB] =
					req.wdata[`XER_STR_MSB:`XER_STR_LSB];
				`SPRN_RET_ADDR:    ret_d   = req.wdata;
				`SPRN_LOOP_COUNT:  cnt_d   = req.wdata;
				`SPRN_FAULT_CAUSE: cause_d = req.wdata;
				`SPRN_FAULT_ADDR:  faddr_d = req.wdata;
				`SPRN_DOWN_COUNT:  dec_d   = req.wdata;
				`SPRN_VEC_SAVE:    vsave_d = req.wdata;
				`SPRN_EXT_ACCESS:  ear_d   = req.wdata;
				`SPRN_TB_LOW_WR:   tbl_d   = req.wdata;
				`SPRN_TB_HIGH_WR:  tbu_d   = req.wdata;
				`SPRN_IMPL_A:      impla_d = req.wdata;
				`SPRN_IMPL_B:      implb_d = req.wdata & `IMPLB_WR_MASK;
				`SPRN_INSTR_BKPT:  instr_breakpoint_addr_d  = req.wdata;
				`SPRN_DATA_BKPT:   data_breakpoint_addr_d  = req.wdata;
				default: ;
			endcase
		end
		// time base up, down counter down
		if (tb_tick) begin
			{tbu_d, tbl_d} = {tbu_d, tbl_d} + 64'h1;
			dec_d = dec_d - 32'h1;
			if (dec_d == 32'hffff_ffff) begin
				dec_irq_d = 1'b1;
			end
		end
		if (br.cr_we) begin
			cr_d[{br.cr_field, 2'b00} +: 4] = br.cr_value;
		end
		if (br.dec_count) begin
			cnt_d = cnt_d - 32'h1;
		end
		if (br.link) begin
			ret_d = br.next_pc;
		end
		if (flt.fault) begin
			faddr_d = flt.addr;
			cause_d = flt.cause;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			xer_q   <= `RST_WORD;
			ret_q   <= `RST_WORD;
			cnt_q   <= `RST_WORD;
			cause_q <= `RST_WORD;
			faddr_q <= `RST_WORD;
			dec_q   <= `RST_WORD;
			vsave_q <= `RST_WORD;
			ear_q   <= `RST_WORD;
			tbl_q   <= `RST_WORD;
			tbu_q   <= `RST_WORD;
			impla_q <= `RST_WORD;
			implb_q <= `RST_WORD;
			instr_breakpoint_addr_q  <= `RST_WORD;
			data_breakpoint_addr_q  <= `RST_WORD;
			cr_q    <= `RST_WORD;
			dec_irq <= 1'b0;
		end else begin
			xer_q   <= xer_d;
			ret_q   <= ret_d;
			cnt_q   <= cnt_d;
			cause_q <= cause_d;
			faddr_q <= faddr_d;
			dec_q   <= dec_d;
			vsave_q <= vsave_d;
			ear_q   <= ear_d;
			tbl_q   <= tbl_d;
			tbu_q   <= tbu_d;
			impla_q <= impla_d;
			implb_q <= implb_d;
			instr_breakpoint_addr_q  <= instr_breakpoint_addr_d;
			data_breakpoint_addr_q  <= data_breakpoint_addr_d;
			cr_q    <= cr_d;
			dec_irq <= dec_irq_d;
		end
	end

	// ----------------------------------------------------------------
	// Reads
	// ----------------------------------------------------------------
	// vector status and data registers are never decoded here.
	always_comb begin
		rsp_d = '0;
		if (req.op == spr_map_pkg::op_move_from_tb) begin
			rsp_d.valid = 1'b1;
			case (req.num)
				`SPRN_TB_LOW_RD:  rsp_d.rdata = tbl_q;
				`SPRN_TB_HIGH_RD: rsp_d.rdata = tbu_q;
				`SPRN_TB_LOW_WR,
				`SPRN_TB_HIGH_WR: rsp_d.illegal = 1'b1;
				default:          rsp_d.unmapped = 1'b1;
			endcase
		end else if (rd) begin
			rsp_d.valid = 1'b1;
			case (req.num)
				// only the string byte is visible
				`SPRN_XER_FLAGS:   rsp_d.rdata[`XER_STR_MSB:`XER_STR_LSB] =
					xer_q[`XER_STR_MSB:`XER_STR_LSB];
				`SPRN_RET_ADDR:    rsp_d.rdata = ret_q;
				`SPRN_LOOP_COUNT:  rsp_d.rdata = cnt_q;
				`SPRN_FAULT_CAUSE: rsp_d.rdata = cause_q;
				`SPRN_FAULT_ADDR:  rsp_d.rdata = faddr_q;
				`SPRN_DOWN_COUNT:  rsp_d.rdata = dec_q;
				`SPRN_VEC_SAVE:    rsp_d.rdata = vsave_q;
				`SPRN_EXT_ACCESS:  rsp_d.rdata = ear_q;
				`SPRN_UMON_A:      rsp_d.rdata = mon_ctl_a;
				`SPRN_UMON_B:      rsp_d.rdata = mon_ctl_b;
				`SPRN_UMON_C:      rsp_d.rdata = mon_ctl_c;
				`SPRN_UCNT_1:      rsp_d.rdata = mon_counts[31:0];
				`SPRN_UCNT_2:      rsp_d.rdata = mon_counts[63:32];
				`SPRN_UCNT_3:      rsp_d.rdata = mon_counts[95:64];
				`SPRN_UCNT_4:      rsp_d.rdata = mon_counts[127:96];
				`SPRN_UCNT_5:      rsp_d.rdata = mon_counts[159:128];
				`SPRN_UCNT_6:      rsp_d.rdata = mon_counts[191:160];
				`SPRN_USAMPLED_PC: rsp_d.rdata = sampled_pc;
				`SPRN_IMPL_A:      rsp_d.rdata = impla_q;
				`SPRN_IMPL_B: begin
					rsp_d.rdata = implb_q;
					rsp_d.rdata[`IMPLB_CLKCFG_MSB:`IMPLB_CLKCFG_LSB] = clk_cfg;
				end
				`SPRN_INSTR_BKPT:  rsp_d.rdata = instr_breakpoint_addr_q;
				`SPRN_DATA_BKPT:   rsp_d.rdata = data_breakpoint_addr_q;
				default:           rsp_d.unmapped = 1'b1;
			endcase
		end else if (wr) begin
			rsp_d.valid = 1'b1;
			case (req.num)
				`SPRN_XER_FLAGS, `SPRN_RET_ADDR, `SPRN_LOOP_COUNT,
				`SPRN_FAULT_CAUSE, `SPRN_FAULT_ADDR, `SPRN_DOWN_COUNT,
				`SPRN_VEC_SAVE, `SPRN_EXT_ACCESS, `SPRN_TB_LOW_WR,
				`SPRN_TB_HIGH_WR, `SPRN_IMPL_A, `SPRN_IMPL_B,
				`SPRN_INSTR_BKPT, `SPRN_DATA_BKPT: ;
				default: rsp_d.unmapped = 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rsp         <= '0;
			cond_flags  <= `RST_WORD;
			loop_target <= `RST_WORD;
			ret_target  <= `RST_WORD;
			impl_a_out  <= `RST_WORD;
		end else begin
			rsp         <= rsp_d;
			cond_flags  <= cr_d;
			loop_target <= cnt_d;
			ret_target  <= ret_d;
			impl_a_out  <= impla_d;
		end
	end

	// ----------------------------------------------------------------
	// Float register file
	// ----------------------------------------------------------------
	// 32 entries, registered read; no reset on the array itself.
	always_ff @(posedge mclk) begin
		if (fpr_we) begin
			fpr_mem[fpr_waddr] <= fpr_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			fpr_rdata <= 64'h0;
		end else begin
			fpr_rdata <= fpr_mem[fpr_raddr];
		end
	end

endmodule // core_special_register_map

`default_nettype wire

// ### move_pipe.sv
`timescale 1ns/1ps
`default_nettype none

// Pipeline side: issues one move at a time and collects its answer.
module move_pipe (
	input  wire logic                  mclk, // Core clock.
	output var  spr_map_pkg::spr_req_t req,  // Move request.
	input  wire spr_map_pkg::spr_rsp_t rsp   // Move answer.
);
	initial req = '0;

	task automatic move(input spr_map_pkg::spr_op_t op,
		input logic [9:0] num, input logic [31:0] wd,
		output spr_map_pkg::spr_rsp_t r);
		@(negedge mclk);
		req = '{op, num, wd};
		@(negedge mclk);
		r = rsp;
		req.op = spr_map_pkg::op_none;
		// Stale data is inverted so that nothing relies on it.
		req.wdata = ~wd;
	endtask
endmodule // move_pipe

`default_nettype wire

// ### spr_map_cfg.svh
`ifndef SPR_MAP_CFG_SVH
`define SPR_MAP_CFG_SVH

// Special-register numbers (10-bit operand field).
`define SPRN_XER_FLAGS    10'h001
`define SPRN_RET_ADDR     10'h008
`define SPRN_LOOP_COUNT   10'h009
`define SPRN_FAULT_CAUSE  10'h012
`define SPRN_FAULT_ADDR   10'h013
`define SPRN_DOWN_COUNT   10'h016
`define SPRN_VEC_SAVE     10'h100
`define SPRN_TB_LOW_RD    10'h10c
`define SPRN_TB_HIGH_RD   10'h10d
`define SPRN_EXT_ACCESS   10'h11a
`define SPRN_TB_LOW_WR    10'h11c
`define SPRN_TB_HIGH_WR   10'h11d
`define SPRN_UMON_C       10'h3a0
`define SPRN_UCNT_5       10'h3a1
`define SPRN_UCNT_6       10'h3a2
`define SPRN_UMON_A       10'h3a8
`define SPRN_UCNT_1       10'h3a9
`define SPRN_UCNT_2       10'h3aa
`define SPRN_USAMPLED_PC  10'h3ab
`define SPRN_UMON_B       10'h3ac
`define SPRN_UCNT_3       10'h3ad
`define SPRN_UCNT_4       10'h3ae
`define SPRN_IMPL_A       10'h3f0
`define SPRN_IMPL_B       10'h3f1
`define SPRN_INSTR_BKPT   10'h3f2
`define SPRN_DATA_BKPT    10'h3f5

// Field layout.
`define XER_STR_LSB       16
`define XER_STR_MSB       23
`define IMPLB_CLKCFG_MSB  5
`define IMPLB_CLKCFG_LSB  0
`define IMPLB_WR_MASK     32'hffff_ffc0
`define BKPT_ENABLE_BIT   0

// Reset values.
`define RST_WORD          32'h0000_0000

// Time base pacing: one tick per four system-bus clock periods.
`define TB_BUS_DIV        4

`endif

// ### spr_map_chk.sv
`timescale 1ns/1ps
`default_nettype none

module spr_map_chk (
	input wire logic                     mclk,        // Core clock.
	input wire logic                     srst,        // Sync reset.
	input wire spr_map_pkg::spr_req_t    req,         // Move request.
	input wire spr_map_pkg::spr_rsp_t    rsp,         // Move answer.
	input wire spr_map_pkg::branch_upd_t br,          // Branch updates.
	input wire logic                     fetch_vld,   // Fetch valid.
	input wire logic                     data_vld,    // Data valid.
	input wire logic [31:0]              cond_flags,  // Condition flags.
	input wire logic [31:0]              loop_target, // Count target.
	input wire logic [31:0]              ret_target,  // Return target.
	input wire logic                     dec_irq,     // Decrementer event.
	input wire logic                     ibkpt_hit,   // Fetch breakpoint.
	input wire logic                     dbkpt_hit    // Data breakpoint.
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	logic is_to;
	logic is_tb;
	assign is_to = req.op == spr_map_pkg::op_move_to;
	assign is_tb = req.op == spr_map_pkg::op_move_from_tb;

	// ------------------------------------------------------------
	// Properties.
	// ------------------------------------------------------------
	a_rsp_follows: assert property (
		req.op != spr_map_pkg::op_none |=> rsp.valid)
		else $error("Move not answered.");
	a_rsp_idle: assert property (
		req.op == spr_map_pkg::op_none |=> !rsp.valid)
		else $error("Answer without move.");
	a_tb_readonly: assert property (
		is_to && req.num inside {10'h10c, 10'h10d} |=> rsp.unmapped)
		else $error("Time base read number took a write.");
	a_tb_illegal: assert property (
		is_tb && req.num inside {10'h11c, 10'h11d} |=> rsp.illegal)
		else $error("Time base write number read without fault.");
	a_link_load: assert property (
		br.link && !is_to |=> ret_target == $past(br.next_pc))
		else $error("Return address not linked.");
	a_loop_dec: assert property (
		br.dec_count && !is_to |=>
		loop_target == $past(loop_target) - 32'h1)
		else $error("Loop count not decremented.");
	a_cr_field: assert property (
		br.cr_we |=>
		cond_flags[4 * $past(br.cr_field) +: 4] == $past(br.cr_value))
		else $error("Condition field not written.");
	a_irq_pulse: assert property (
		dec_irq |=> !dec_irq) else $error("Decrementer event too long.");
	a_ibkpt_quiet: assert property (
		!fetch_vld |=> !ibkpt_hit) else $error("Fetch breakpoint without fetch.");
	a_dbkpt_quiet: assert property (
		!data_vld |=> !dbkpt_hit) else $error("Data breakpoint without access.");

	c_tb_illegal: cover property (is_tb ##1 rsp.illegal);
	c_dec_irq: cover property (dec_irq);
	c_ibkpt: cover property (ibkpt_hit);
	c_dbkpt: cover property (dbkpt_hit);
endmodule // spr_map_chk

`default_nettype wire

// ### spr_map_pkg.sv
package spr_map_pkg;

	typedef enum logic [1:0] {
		op_none,
		op_move_to,
		op_move_from,
		op_move_from_tb
	} spr_op_t;

	typedef struct packed {
		spr_op_t     op;
		logic [9:0]  num;
		logic [31:0] wdata;
	} spr_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
		logic        illegal;
		logic        unmapped;
	} spr_rsp_t;

	typedef struct packed {
		logic        fault;
		logic [31:0] addr;
		logic [31:0] cause;
	} fault_info_t;

	typedef struct packed {
		logic        link;
		logic [31:0] next_pc;
		logic        dec_count;
		logic        cr_we;
		logic [2:0]  cr_field;
		logic [3:0]  cr_value;
	} branch_upd_t;

endpackage

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam spr_map_pkg::spr_op_t op_to = spr_map_pkg::op_move_to;
	localparam spr_map_pkg::spr_op_t op_fr = spr_map_pkg::op_move_from;
	localparam spr_map_pkg::spr_op_t op_tb = spr_map_pkg::op_move_from_tb;

	logic                      mclk, srst, bus_tick, fpr_we;
	logic                      fetch_vld, data_vld, dec_irq;
	logic                      ibkpt_hit, dbkpt_hit;
	logic [4:0]                fpr_raddr, fpr_waddr;
	logic [5:0]                clk_cfg;
	logic [31:0]               mon_ctl_a, mon_ctl_b, mon_ctl_c, sampled_pc;
	logic [31:0]               fetch_addr, data_addr, cond_flags;
	logic [31:0]               loop_target, ret_target, impl_a_out;
	logic [63:0]               fpr_wdata, fpr_rdata;
	logic [191:0]              mon_counts;
	spr_map_pkg::spr_req_t     req;
	spr_map_pkg::spr_rsp_t     rsp;
	spr_map_pkg::branch_upd_t  br;
	spr_map_pkg::fault_info_t  flt;
	int                        fail_count, samples_checked, cyc;
	int                        irq_n, ib_n, db_n;
	logic [9:0]                rw_num [8] = '{10'h009, 10'h008, 10'h012,
		10'h013, 10'h100, 10'h3f0, 10'h3f2, 10'h3f5};
	logic [9:0]                cnt_num [6] = '{10'h3a9, 10'h3aa, 10'h3ad,
		10'h3ae, 10'h3a1, 10'h3a2};

	move_pipe pipe_u (.mclk(mclk), .req(req), .rsp(rsp));

	core_special_register_map dut_u (.mclk(mclk), .srst(srst), .req(req),
		.rsp(rsp), .br(br), .flt(flt), .bus_tick(bus_tick),
		.clk_cfg(clk_cfg), .mon_ctl_a(mon_ctl_a), .mon_ctl_b(mon_ctl_b),
		.mon_ctl_c(mon_ctl_c), .mon_counts(mon_counts),
		.sampled_pc(sampled_pc), .fetch_vld(fetch_vld),
		.fetch_addr(fetch_addr), .data_vld(data_vld),
		.data_addr(data_addr), .fpr_raddr(fpr_raddr), .fpr_we(fpr_we),
		.fpr_waddr(fpr_waddr), .fpr_wdata(fpr_wdata),
		.fpr_rdata(fpr_rdata), .cond_flags(cond_flags),
		.loop_target(loop_target), .ret_target(ret_target),
		.dec_irq(dec_irq), .ibkpt_hit(ibkpt_hit), .dbkpt_hit(dbkpt_hit),
		.impl_a_out(impl_a_out));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Event pulses last one cycle, so they are counted as they pass.
	always @(posedge mclk) begin
		cyc++;
		if (dec_irq === 1'b1) irq_n++;
		if (ibkpt_hit === 1'b1) ib_n++;
		if (dbkpt_hit === 1'b1) db_n++;
		if (cyc == 5000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input spr_map_pkg::spr_op_t op, input logic [9:0] n,
		input logic [31:0] wd, input logic [31:0] exp, input logic [1:0] fl);
		spr_map_pkg::spr_rsp_t r;
		pipe_u.move(op, n, wd, r);
		chk({r.valid, r.illegal, r.unmapped}, {1'b1, fl});
		if (op != op_to && fl == 2'b00) chk(r.rdata, exp);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge mclk) bus_tick = 1'b1;
			@(negedge mclk) bus_tick = 1'b0;
		end
		repeat (3) @(negedge mclk);
	endtask

	task automatic probe(input logic [31:0] fa, input logic [31:0] da);
		@(negedge mclk);
		fetch_vld = 1'b1;
		fetch_addr = fa;
		data_vld = 1'b1;
		data_addr = da;
		@(negedge mclk);
		fetch_vld = 1'b0;
		data_vld = 1'b0;
		repeat (2) @(negedge mclk);
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	initial begin
		srst = 1'b1;
		br = '0;
		flt = '0;
		bus_tick = 1'b0;
		clk_cfg = 6'h2a;
		mon_ctl_a = 32'h1111_00a0;
		mon_ctl_b = 32'h2222_00b0;
		mon_ctl_c = 32'h3333_00c0;
		mon_counts = {32'h66, 32'h55, 32'h44, 32'h33, 32'h22, 32'h11};
		sampled_pc = 32'h0000_7ffc;
		{fetch_vld, data_vld, fpr_we} = 3'b000;
		{fetch_addr, data_addr} = 64'h0;
		{fpr_raddr, fpr_waddr, fpr_wdata} = '0;
		repeat (6) @(posedge mclk);
		@(negedge mclk) srst = 1'b0;
		for (int i = 0; i < 8; i++) acc(op_fr, rw_num[i], 0, 0, 0);
		for (int i = 0; i < 8; i++)
			acc(op_to, rw_num[i], 32'h5a5a_0000 | i, 0, 0);
		for (int i = 0; i < 8; i++)
			acc(op_fr, rw_num[i], 0, 32'h5a5a_0000 | i, 0);
		chk(impl_a_out, 32'h5a5a_0005);
		acc(op_to, 10'h11a, 0, 0, 0);
		acc(op_fr, 10'h11a, 0, 0, 0);
		acc(op_to, 10'h001, 32'hffff_ffff, 0, 0);
		acc(op_fr, 10'h001, 0, 32'h00ff_0000, 0);
		acc(op_to, 10'h3f1, 32'hffff_ffff, 0, 0);
		acc(op_fr, 10'h3f1, 0, 32'hffff_ffea, 0);
		acc(op_to, 10'h3ff, 32'h1, 0, 2'b01);
		acc(op_fr, 10'h10c, 0, 0, 2'b01);
		$display("Test registers done");
		acc(op_fr, 10'h3a8, 0, mon_ctl_a, 0);
		acc(op_fr, 10'h3ac, 0, mon_ctl_b, 0);
		acc(op_fr, 10'h3a0, 0, mon_ctl_c, 0);
		acc(op_to, 10'h3a8, 32'h0, 0, 2'b01);
		acc(op_fr, 10'h3ab, 0, sampled_pc, 0);
		for (int i = 0; i < 6; i++)
			acc(op_fr, cnt_num[i], 0, mon_counts[32 * i +: 32], 0);
		$display("Test monitor views done");
		acc(op_to, 10'h016, 32'h1, 0, 0);
		acc(op_to, 10'h11c, 32'hffff_ffff, 0, 0);
		acc(op_to, 10'h11d, 32'h7, 0, 0);
		acc(op_to, 10'h10d, 32'h9, 0, 2'b01);
		acc(op_tb, 10'h10c, 0, 32'hffff_ffff, 0);
		acc(op_tb, 10'h10d, 0, 32'h7, 0);
		acc(op_tb, 10'h11c, 0, 0, 2'b10);
		acc(op_tb, 10'h11d, 0, 0, 2'b10);
		acc(op_tb, 10'h016, 0, 0, 2'b01);
		// Three bus clocks must not move the time base; the fourth must.
		ticks(3);
		acc(op_tb, 10'h10c, 0, 32'hffff_ffff, 0);
		ticks(1);
		acc(op_tb, 10'h10c, 0, 32'h0, 0);
		acc(op_tb, 10'h10d, 0, 32'h8, 0);
		acc(op_fr, 10'h016, 0, 32'h0, 0);
		chk(64'(irq_n), 64'h0);
		ticks(4);
		acc(op_fr, 10'h016, 0, 32'hffff_ffff, 0);
		chk(64'(irq_n), 64'h1);
		$display("Test time base done");
		@(negedge mclk);
		br = '{1'b1, 32'h0000_4444, 1'b1, 1'b1, 3'h3, 4'ha};
		@(negedge mclk);
		br = '0;
		chk(ret_target, 32'h0000_4444);
		chk(loop_target, 32'h5a59_ffff);
		chk(cond_flags, 32'h0000_a000);
		acc(op_fr, 10'h008, 0, 32'h0000_4444, 0);
		acc(op_fr, 10'h009, 0, 32'h5a59_ffff, 0);
		@(negedge mclk);
		flt = '{1'b1, 32'h0bad_0010, 32'h0200_0000};
		@(negedge mclk);
		flt = '0;
		acc(op_fr, 10'h013, 0, 32'h0bad_0010, 0);
		acc(op_fr, 10'h012, 0, 32'h0200_0000, 0);
		acc(op_fr, 10'h100, 0, 32'h5a5a_0004, 0);
		$display("Test branch and fault done");
		acc(op_to, 10'h3f2, 32'h0000_1001, 0, 0);
		acc(op_to, 10'h3f5, 32'h0000_2001, 0, 0);
		probe(32'h0000_1004, 32'h0000_2004);
		chk({ib_n[1:0], db_n[1:0]}, 4'h0);
		probe(32'h0000_1002, 32'h0000_2003);
		chk({ib_n[1:0], db_n[1:0]}, 4'h5);
		@(negedge mclk);
		fpr_we = 1'b1;
		fpr_waddr = 5'h1f;
		fpr_wdata = 64'h0123_4567_89ab_cdef;
		@(negedge mclk);
		fpr_we = 1'b0;
		fpr_raddr = 5'h1f;
		@(negedge mclk);
		chk(fpr_rdata, 64'h0123_4567_89ab_cdef);
		$display("Test breakpoints and float file done");
		finish_test();
	end
endmodule // tb_top

bind core_special_register_map spr_map_chk chk_u (.mclk(mclk),
	.srst(srst), .req(req), .rsp(rsp), .br(br), .fetch_vld(fetch_vld),
	.data_vld(data_vld), .cond_flags(cond_flags),
	.loop_target(loop_target), .ret_target(ret_target), .dec_irq(dec_irq),
	.ibkpt_hit(ibkpt_hit), .dbkpt_hit(dbkpt_hit));

`default_nettype wire

// ### tick_divider.sv
`timescale 1ns/1ps
`default_nettype none

// Produces one enable pulse for every DIV pulses of bus_tick.
module tick_divider #(
	parameter int unsigned DIV = 4
) (
	input  wire logic mclk,     // Core clock.
	input  wire logic srst,     // Synchronous reset.
	input  wire logic bus_tick, // One pulse per system-bus clock.
	output var  logic tick      // One pulse per DIV bus clocks.
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       tick_d;

	always_comb begin
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (bus_tick) begin
			if (cnt_q == 8'(DIV - 1)) begin
				cnt_d  = 8'h00;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_q <= 8'h00;
			tick  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick  <= tick_d;
		end
	end

endmodule // tick_divider

`default_nettype wire
